// [include/idebm_pkg.sv]
// Shared constants for the dual-channel scatter/gather IDE DMA controller
package idebm_pkg;
	// IO window: 16 bytes, two channels of two dwords each
	localparam int          IO_WIN_BITS    = 4;
	localparam logic [3:0]  OFS_CMD_PRI    = 4'h0;
	localparam logic [3:0]  OFS_STATUS_PRI = 4'h2;
	localparam logic [3:0]  OFS_PTR_PRI    = 4'h4;
	localparam logic [3:0]  OFS_CMD_SEC    = 4'h8;
	localparam logic [3:0]  OFS_STATUS_SEC = 4'ha;
	localparam logic [3:0]  OFS_PTR_SEC    = 4'hc;
	localparam int          CH_SEL_BIT     = 3;
	localparam int          DW_SEL_BIT     = 2;
	localparam int          LANE_CMD       = 0;
	localparam int          LANE_STATUS    = 2;
	// Command and status fields
	localparam int          CMD_START      = 0;
	localparam int          CMD_DIR        = 3;
	localparam int          ST_SIMPLEX     = 7;
	localparam int          ST_CAP1        = 6;
	localparam int          ST_CAP0        = 5;
	localparam int          ST_INTR        = 2;
	localparam int          ST_ERR         = 1;
	localparam int          ST_ACTIVE      = 0;
	localparam logic        SIMPLEX_ONLY   = 1'b0;
	localparam logic [7:0]  STATUS_RST     = 8'h00;
	localparam logic [29:0] PTR_RST        = 30'h00000000;
	// Descriptor layout
	localparam logic [31:0] DESC_STEP      = 32'h00000008;
	localparam logic [31:0] DESC_CNT_OFS   = 32'h00000004;
	localparam int          DESC_END_BIT   = 31;
	localparam logic [16:0] CNT_FULL       = 17'h10000;
	localparam logic [16:0] WORD_BYTES     = 17'h00004;
	localparam logic [31:0] ADDR_STEP      = 32'h00000004;
	// Configuration space
	localparam logic [5:0]  CFG_IDX_ID     = 6'h00;
	localparam logic [5:0]  CFG_IDX_CMDST  = 6'h01;
	localparam logic [5:0]  CFG_IDX_CLASS  = 6'h02;
	localparam logic [5:0]  CFG_IDX_BAR    = 6'h08;
	localparam logic [15:0] CLASS_IDE      = 16'h0101;
	localparam logic [7:0]  PROG_IF        = 8'h80;
	localparam logic [15:0] VENDOR_CODE    = 16'h1234; // Arbitrary value
	localparam logic [15:0] DEVICE_CODE    = 16'h5678; // Arbitrary value
	localparam logic [7:0]  REVISION_CODE  = 8'h01;    // Arbitrary value
	localparam int          CFGCMD_IO_EN   = 0;
	localparam int          CFGST_PERR     = 8;
	localparam int          CFGST_TABORT   = 12;
	localparam int          CFGST_MABORT   = 13;
	localparam int          CFG_ST_LSB     = 16;
	localparam logic        BAR_IO_FLAG    = 1'b1;
endpackage

// [hw/idebm_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module idebm_sync #(
	parameter int W = 1
) (
	input  wire logic         i_ref_clk, // Clock
	input  wire logic         i_arst_n,  // Async reset, active low
	input  wire logic [W-1:0] i_async,   // Pin level
	output logic      [W-1:0] o_sync     // Synchronised level
);
	logic [W-1:0] meta;

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// [hw/idebm_chan.sv]
// One DMA channel: descriptor walk and word mover
`timescale 1ns/1ns
module idebm_chan (
	input  wire logic        i_ref_clk,  // Clock
	input  wire logic        i_arst_n,   // Async reset, active low
	input  wire logic        i_start,    // Command start bit
	input  wire logic        i_dir,      // 1: write memory
	input  wire logic [29:0] i_ptr,      // Table base, dword aligned
	input  wire logic        i_bus_mine, // Own access still in flight
	input  wire logic        i_done,     // Access finished pulse
	input  wire logic        i_err,      // Access failed, with done
	input  wire logic [31:0] i_rdata,    // Read data, with done
	output logic             o_req,      // Access request level
	output logic             o_we,       // Access is a write
	output logic      [31:0] o_addr,     // Access address
	output logic      [31:0] o_wdata,    // Access write data
	output logic             o_active,   // Active status bit
	output logic             o_buffered, // Drive data not yet in memory
	output logic             o_err,      // Error event pulse
	input  wire logic        i_rx_valid, // Word from drive valid
	input  wire logic [31:0] i_rx_data,  // Word from drive
	output logic             o_rx_ready, // Word from drive taken
	output logic             o_tx_valid, // Word to drive valid
	output logic      [31:0] o_tx_data,  // Word to drive
	input  wire logic        i_tx_ready  // Word to drive taken
);
	import idebm_pkg::*;

	typedef enum logic [5:0] {
		S_IDLE    = 6'h01,
		S_FETCH_A = 6'h02,
		S_FETCH_B = 6'h04,
		S_MOVE    = 6'h08,
		S_MEMOP   = 6'h10,
		S_GIVE    = 6'h20
	} idebm_chan_state_t;

	idebm_chan_state_t state;
	logic              start_q;
	logic              launch;
	logic       [31:0] desc;
	logic       [31:0] region;
	logic       [16:0] count;
	logic              end_of_table_flag;

	wire last_word = count <= WORD_BYTES;
	wire advance   = (state == S_MEMOP && i_done && !i_err && o_we) ||
	                 (state == S_GIVE && i_tx_ready);
	wire fail      = i_done && i_err && (state == S_FETCH_A || state == S_FETCH_B ||
	                 state == S_MEMOP);
	wire [16:0] next_count = (i_rdata[15:0] == 16'h0000) ? CNT_FULL : {1'b0, i_rdata[15:0]};

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			start_q <= 1'b0;
			launch  <= 1'b0;
		end else begin
			start_q <= i_start;
			if (!i_start || state != S_IDLE)
				launch <= 1'b0;
			else if (!start_q)
				launch <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state      <= S_IDLE;
			o_req      <= 1'b0;
			o_we       <= 1'b0;
			o_addr     <= '0;
			o_wdata    <= '0;
			o_active   <= 1'b0;
			o_buffered <= 1'b0;
			o_err      <= 1'b0;
			o_rx_ready <= 1'b0;
			o_tx_valid <= 1'b0;
			o_tx_data  <= '0;
			desc       <= '0;
			region     <= '0;
			count      <= '0;
			end_of_table_flag <= 1'b0;
		end else begin
			o_err <= 1'b0;
			if (i_start && !start_q)
				o_active <= 1'b1;
			if (!i_start) begin
				// Abort drops everything; a stale access finishes on its own
				state      <= S_IDLE;
				o_active   <= 1'b0;
				o_req      <= 1'b0;
				o_buffered <= 1'b0;
				o_rx_ready <= 1'b0;
				o_tx_valid <= 1'b0;
			end else if (fail) begin
				state      <= S_IDLE;
				o_active   <= 1'b0;
				o_err      <= 1'b1;
				o_req      <= 1'b0;
				o_buffered <= 1'b0;
			end else begin
				case (state)
				S_IDLE: begin
					if (launch && !i_bus_mine) begin
						desc   <= {i_ptr, 2'b00};
						o_addr <= {i_ptr, 2'b00};
						o_we   <= 1'b0;
						o_req  <= 1'b1;
						state  <= S_FETCH_A;
					end
				end
				S_FETCH_A: begin
					if (i_done) begin
						region <= i_rdata;
						o_addr <= desc + DESC_CNT_OFS;
						state  <= S_FETCH_B;
					end
				end
				S_FETCH_B: begin
					if (i_done) begin
						o_req <= 1'b0;
						count <= next_count;
						end_of_table_flag <= i_rdata[DESC_END_BIT];
						desc  <= desc + DESC_STEP;
						state <= S_MOVE;
					end
				end
				S_MOVE: begin
					if (i_dir) begin
						o_rx_ready <= !(i_rx_valid && o_rx_ready);
						if (i_rx_valid && o_rx_ready) begin
							o_wdata    <= i_rx_data;
							o_buffered <= 1'b1;
							o_addr     <= region;
							o_we       <= 1'b1;
							o_req      <= 1'b1;
							state      <= S_MEMOP;
						end
					end else begin
						o_addr <= region;
						o_we   <= 1'b0;
						o_req  <= 1'b1;
						state  <= S_MEMOP;
					end
				end
				S_MEMOP: begin
					if (i_done) begin
						o_req      <= 1'b0;
						o_buffered <= 1'b0;
						if (!o_we) begin
							o_tx_data  <= i_rdata;
							o_tx_valid <= 1'b1;
							state      <= S_GIVE;
						end
					end
				end
				S_GIVE: begin
					if (i_tx_ready)
						o_tx_valid <= 1'b0;
				end
				default: state <= S_IDLE;
				endcase
				if (advance) begin
					region <= region + ADDR_STEP;
					count  <= count - WORD_BYTES;
					if (!last_word) begin
						state <= S_MOVE;
					end else if (end_of_table_flag) begin
						state    <= S_IDLE;
						o_active <= 1'b0;
					end else begin
						o_addr <= desc;
						o_we   <= 1'b0;
						o_req  <= 1'b1;
						state  <= S_FETCH_A;
					end
				end
			end
		end
	end
endmodule

// [hw/idebm_top.sv]
// Dual-channel bus-master IDE DMA controller: registers, config space, bus master
`timescale 1ns/1ns
module idebm_top (
	input  wire logic             i_ref_clk,    // 50 MHz clock
	input  wire logic             i_arst_n,     // Async reset, active low
	input  wire logic             i_io_rd,      // IO read request, held to ack
	input  wire logic             i_io_wr,      // IO write request, held to ack
	input  wire logic [31:0]      i_io_addr,    // IO byte address
	input  wire logic [3:0]       i_io_be,      // IO byte enables
	input  wire logic [31:0]      i_io_wdata,   // IO write data
	output logic                  o_io_ack,     // IO access done pulse
	output logic      [31:0]      o_io_rdata,   // IO read data, with ack
	input  wire logic             i_cfg_rd,     // Config read, held to ack
	input  wire logic             i_cfg_wr,     // Config write, held to ack
	input  wire logic [7:0]       i_cfg_addr,   // Config byte offset
	input  wire logic [3:0]       i_cfg_be,     // Config byte enables
	input  wire logic [31:0]      i_cfg_wdata,  // Config write data
	output logic                  o_cfg_ack,    // Config access done pulse
	output logic      [31:0]      o_cfg_rdata,  // Config read data, with ack
	output logic                  o_mem_req,    // Master access request
	output logic                  o_mem_we,     // Master access is write
	output logic      [31:0]      o_mem_addr,   // Master address
	output logic      [31:0]      o_mem_wdata,  // Master write data
	input  wire logic             i_mem_ack,    // Master access completed
	input  wire logic [31:0]      i_mem_rdata,  // Master read data
	input  wire logic             i_mem_tabort, // Target abort seen
	input  wire logic             i_mem_mabort, // Master abort seen
	input  wire logic             i_mem_perr,   // Data parity error seen
	input  wire logic [1:0]       i_intrq,      // Drive interrupt pins
	output logic      [1:0]       o_chan_active,// Active bit per channel
	input  wire logic [1:0]       i_rx_valid,   // Word from drive valid
	input  wire logic [1:0][31:0] i_rx_data,    // Word from drive
	output logic      [1:0]       o_rx_ready,   // Word from drive taken
	output logic      [1:0]       o_tx_valid,   // Word to drive valid
	output logic      [1:0][31:0] o_tx_data,    // Word to drive
	input  wire logic [1:0]       i_tx_ready    // Word to drive taken
);
	import idebm_pkg::*;

	function automatic logic [7:0] status_byte(input logic c1, input logic c0,
			input logic intr_b, input logic err_b, input logic act_b);
		status_byte              = STATUS_RST;
		status_byte[ST_SIMPLEX]  = SIMPLEX_ONLY;
		status_byte[ST_CAP1]     = c1;
		status_byte[ST_CAP0]     = c0;
		status_byte[ST_INTR]     = intr_b;
		status_byte[ST_ERR]      = err_b;
		status_byte[ST_ACTIVE]   = act_b;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			be_merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
	endfunction

	logic [1:0]       cmd_start;
	logic [1:0]       cmd_dir;
	logic [1:0]       cap1;
	logic [1:0]       cap0;
	logic [1:0]       intr;
	logic [1:0]       err;
	logic [1:0][29:0] ptr;
	logic [1:0]       intrq_s;
	logic [1:0]       intrq_q;
	logic [27:0]      bar;
	logic             io_en;
	logic             cst_perr;
	logic             cst_tabort;
	logic             cst_mabort;
	logic             bus_owner;
	logic [1:0]       mem_done;
	logic [1:0]       mem_err;
	logic [31:0]      mem_rdata;
	logic [1:0]       ch_req;
	logic [1:0]       ch_we;
	logic [1:0][31:0] ch_addr;
	logic [1:0][31:0] ch_wdata;
	logic [1:0]       ch_buffered;
	logic [1:0]       ch_err;

	idebm_sync #(.W(2)) u_intrq_sync (
		.i_ref_clk (i_ref_clk),
		.i_arst_n  (i_arst_n),
		.i_async   (i_intrq),
		.o_sync    (intrq_s)
	);

	for (genvar c = 0; c < 2; c++) begin : g_chan
		idebm_chan u_chan (
			.i_ref_clk  (i_ref_clk),
			.i_arst_n   (i_arst_n),
			.i_start    (cmd_start[c]),
			.i_dir      (cmd_dir[c]),
			.i_ptr      (ptr[c]),
			.i_bus_mine ((o_mem_req && bus_owner == 1'(c)) || mem_done[c]),
			.i_done     (mem_done[c]),
			.i_err      (mem_err[c]),
			.i_rdata    (mem_rdata),
			.o_req      (ch_req[c]),
			.o_we       (ch_we[c]),
			.o_addr     (ch_addr[c]),
			.o_wdata    (ch_wdata[c]),
			.o_active   (o_chan_active[c]),
			.o_buffered (ch_buffered[c]),
			.o_err      (ch_err[c]),
			.i_rx_valid (i_rx_valid[c]),
			.i_rx_data  (i_rx_data[c]),
			.o_rx_ready (o_rx_ready[c]),
			.o_tx_valid (o_tx_valid[c]),
			.o_tx_data  (o_tx_data[c]),
			.i_tx_ready (i_tx_ready[c])
		);
	end

	// IO decode
	wire       io_hit   = io_en && (i_io_addr[31:IO_WIN_BITS] == bar);
	wire       io_ch    = i_io_addr[CH_SEL_BIT];
	wire       io_dw    = i_io_addr[DW_SEL_BIT];
	// A status read waits while a drive word is still bound for memory
	wire       io_stall = i_io_rd && io_hit && !io_dw && i_io_be[LANE_STATUS] &&
	                      ch_buffered[io_ch];
	wire       io_take  = (i_io_rd || i_io_wr) && !o_io_ack && !io_stall;
	wire       io_wr_ok = io_take && i_io_wr && io_hit;
	wire [1:0] io_chsel = {io_ch, !io_ch};
	wire [1:0] wr_ctl   = {2{io_wr_ok && !io_dw}} & io_chsel;
	wire [1:0] wr_ptr   = {2{io_wr_ok && io_dw}} & io_chsel;
	wire [7:0] wst      = i_io_wdata[8*LANE_STATUS +: 8];
	wire [7:0] wcmd     = i_io_wdata[8*LANE_CMD +: 8];
	wire [1:0] cmd_wr   = wr_ctl & {2{i_io_be[LANE_CMD]}};
	wire [1:0] st_wr    = wr_ctl & {2{i_io_be[LANE_STATUS]}};
	// Write-one-clear requests for the sticky flags
	wire [1:0] intr_clr = st_wr & {2{wst[ST_INTR]}};
	wire [1:0] err_clr  = st_wr & {2{wst[ST_ERR]}};
	wire [31:0] ptr_new = be_merge({ptr[io_ch], 2'b00}, i_io_wdata, i_io_be);
	wire [1:0] intr_rise = intrq_s & ~intrq_q;
	wire [7:0] rd_status = status_byte(cap1[io_ch], cap0[io_ch], intr[io_ch],
	                       err[io_ch], o_chan_active[io_ch]);
	wire [7:0] rd_cmd    = {4'h0, cmd_dir[io_ch], 2'b00, cmd_start[io_ch]};
	wire [31:0] rd_ctl   = {8'h00, rd_status, 8'h00, rd_cmd};
	wire [31:0] rd_word  = !io_hit ? 32'h00000000 :
	                       io_dw ? {ptr[io_ch], 2'b00} : rd_ctl;

	// Config decode
	wire        cfg_take = (i_cfg_rd || i_cfg_wr) && !o_cfg_ack;
	wire [5:0]  cfg_idx  = i_cfg_addr[7:2];
	wire        cfg_wr   = cfg_take && i_cfg_wr;
	wire        cs_wr    = cfg_wr && cfg_idx == CFG_IDX_CMDST;
	wire        bar_wr   = cfg_wr && cfg_idx == CFG_IDX_BAR;
	wire [31:0] bar_new  = be_merge({bar, 4'h0}, i_cfg_wdata, i_cfg_be);
	wire [15:0] cfg_st   = 16'(({15'h0, cst_perr} << CFGST_PERR) |
	                       ({15'h0, cst_tabort} << CFGST_TABORT) |
	                       ({15'h0, cst_mabort} << CFGST_MABORT));
	wire [31:0] cfg_word = (cfg_idx == CFG_IDX_ID) ? {DEVICE_CODE, VENDOR_CODE} :
	                       (cfg_idx == CFG_IDX_CMDST) ? {cfg_st, 15'h0000, io_en} :
	                       (cfg_idx == CFG_IDX_CLASS) ? {CLASS_IDE, PROG_IF, REVISION_CODE} :
	                       (cfg_idx == CFG_IDX_BAR) ? {bar, 3'b000, BAR_IO_FLAG} :
	                       32'h00000000;
	wire [31:0] cfg_clr  = cs_wr ?
	                       be_merge(32'h00000000, i_cfg_wdata, i_cfg_be) : 32'h00000000;

	// Shared bus master; fixed priority, one access in flight
	wire bus_fail = o_mem_req && (i_mem_tabort || i_mem_mabort || i_mem_perr);
	wire bus_end  = o_mem_req && (i_mem_ack || bus_fail);
	wire bus_free = !o_mem_req && (mem_done == 2'b00);
	wire take0    = bus_free && ch_req[0];
	wire take1    = bus_free && !ch_req[0] && ch_req[1];
	// Fault causes are logged only for our own master cycle
	wire [2:0] cause_set = {3{bus_fail}} & {i_mem_mabort, i_mem_tabort, i_mem_perr};

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_req   <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= '0;
			o_mem_wdata <= '0;
			bus_owner   <= 1'b0;
			mem_done    <= 2'b00;
			mem_err     <= 2'b00;
			mem_rdata   <= '0;
		end else begin
			mem_done <= 2'b00;
			mem_err  <= 2'b00;
			if (take0 || take1) begin
				o_mem_req   <= 1'b1;
				bus_owner   <= take1;
				o_mem_we    <= ch_we[take1];
				o_mem_addr  <= ch_addr[take1];
				o_mem_wdata <= ch_wdata[take1];
			end else if (bus_end) begin
				o_mem_req           <= 1'b0;
				mem_done[bus_owner] <= 1'b1;
				mem_err[bus_owner]  <= bus_fail;
				mem_rdata           <= i_mem_rdata;
			end
		end
	end

	// Channel registers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmd_start <= 2'b00;
			cmd_dir   <= 2'b00;
			cap1      <= 2'b00;
			cap0      <= 2'b00;
			ptr       <= {PTR_RST, PTR_RST};
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (cmd_wr[c]) begin
					cmd_start[c] <= wcmd[CMD_START];
					cmd_dir[c]   <= wcmd[CMD_DIR];
				end
				if (st_wr[c]) begin
					cap1[c] <= wst[ST_CAP1];
					cap0[c] <= wst[ST_CAP0];
				end
				if (wr_ptr[c])
					ptr[c] <= ptr_new[31:2];
			end
		end
	end

	// Sticky flags; a set wins over a write-one clear in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			intr    <= 2'b00;
			err     <= 2'b00;
			intrq_q <= 2'b00;
		end else begin
			intrq_q <= intrq_s;
			intr    <= intr_rise | (intr & ~intr_clr);
			err     <= ch_err | (err & ~err_clr);
		end
	end

	// IO answers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_io_ack   <= 1'b0;
			o_io_rdata <= '0;
		end else begin
			o_io_ack   <= io_take;
			o_io_rdata <= (io_take && i_io_rd) ? rd_word : 32'h00000000;
		end
	end

	// Config answers and state
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_cfg_ack   <= 1'b0;
			o_cfg_rdata <= '0;
			bar         <= '0;
			io_en       <= 1'b0;
			cst_perr    <= 1'b0;
			cst_tabort  <= 1'b0;
			cst_mabort  <= 1'b0;
		end else begin
			o_cfg_ack   <= cfg_take;
			o_cfg_rdata <= (cfg_take && i_cfg_rd) ? cfg_word : 32'h00000000;
			if (bar_wr)
				bar <= bar_new[31:IO_WIN_BITS];
			if (cs_wr && i_cfg_be[0])
				io_en <= i_cfg_wdata[CFGCMD_IO_EN];
			cst_perr   <= cause_set[0] ||
			              (cst_perr && !cfg_clr[CFG_ST_LSB + CFGST_PERR]);
			cst_tabort <= cause_set[1] ||
			              (cst_tabort && !cfg_clr[CFG_ST_LSB + CFGST_TABORT]);
			cst_mabort <= cause_set[2] ||
			              (cst_mabort && !cfg_clr[CFG_ST_LSB + CFGST_MABORT]);
		end
	end
endmodule

// [tb/idebm_checker.sv]
// Port-level checks for the IDE DMA controller top
`timescale 1ns/1ns
module idebm_checker
	import idebm_pkg::*;
(
	input wire logic        i_ref_clk,    // Clock
	input wire logic        i_arst_n,     // Reset
	input wire logic        i_io_rd,      // IO read
	input wire logic [31:0] i_io_addr,    // IO addr
	input wire logic        o_io_ack,     // IO ack
	input wire logic [31:0] o_io_rdata,   // IO data
	input wire logic        i_cfg_rd,     // Cfg read
	input wire logic [7:0]  i_cfg_addr,   // Cfg addr
	input wire logic        o_cfg_ack,    // Cfg ack
	input wire logic [31:0] o_cfg_rdata,  // Cfg data
	input wire logic        o_mem_req,    // Mem req
	input wire logic [31:0] o_mem_addr,   // Mem addr
	input wire logic        i_mem_ack,    // Mem ack
	input wire logic        i_mem_tabort, // Abort
	input wire logic        i_mem_mabort, // Abort
	input wire logic        i_mem_perr,   // Parity
	input wire logic [1:0]  o_chan_active // Active
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	wire rd_ack = o_io_ack && i_io_rd;
	wire fail   = o_mem_req && (i_mem_tabort || i_mem_mabort || i_mem_perr);
	a_simplex_bit: assert property (rd_ack && !i_io_addr[2] |-> o_io_rdata[23] == SIMPLEX_ONLY)
		else $error("simplex bit");
	a_status_rsvd: assert property (rd_ack && !i_io_addr[2] |-> o_io_rdata[20:19] == 2'h0)
		else $error("reserved bits");
	a_ptr_align: assert property (rd_ack && i_io_addr[2] |-> o_io_rdata[1:0] == 2'h0)
		else $error("pointer low bits");
	a_fail_stops: assert property (fail |-> ##[1:6] o_chan_active == 2'h0)
		else $error("active after fault");
	a_mem_hold: assert property (o_mem_req && !i_mem_ack && !fail |=> o_mem_req && $stable(o_mem_addr))
		else $error("master request dropped");
	a_mem_gap: assert property ($fell(o_mem_req) |=> !o_mem_req)
		else $error("master gap");
	a_read_done: assert property (i_io_rd && !o_io_ack |-> ##[1:60] o_io_ack)
		else $error("read stalled");
	a_class_code: assert property (o_cfg_ack && i_cfg_rd && i_cfg_addr[7:2] == CFG_IDX_CLASS
		|-> o_cfg_rdata[31:15] == {CLASS_IDE, 1'b1})
		else $error("class code");
endmodule
bind idebm_top idebm_checker chk (.*);

// [tb/idebm_mem_model.sv]
// Host memory behind the master port, with wait states and bus faults
`timescale 1ns/1ns
module idebm_mem_model (
	input  wire logic        i_ref_clk, // Clock
	input  wire logic        i_arst_n,  // Reset
	input  wire logic        i_req,     // Request
	input  wire logic        i_we,      // Write
	input  wire logic [31:0] i_addr,    // Address
	input  wire logic [31:0] i_wdata,   // Write data
	input  wire logic [3:0]  i_lat,     // Wait states
	input  wire logic [1:0]  i_fault,   // Fault kind
	output logic             o_ack,     // Done
	output logic      [31:0] o_rdata,   // Read data
	output logic      [2:0]  o_abort    // Fault pulse
);
	logic [31:0] mem [logic [31:0]];
	logic [3:0]  cnt;
	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt <= 4'h0;
			o_ack <= 1'b0;
			o_abort <= 3'h0;
			o_rdata <= 32'h0;
		end else begin
			o_ack <= 1'b0;
			o_abort <= 3'h0;
			o_rdata <= ~o_rdata; // Complement the bus data each cycle; it is a read value only with ack
			if (!i_req || o_ack || o_abort != 3'h0) begin
				cnt <= 4'h0;
			end else if (cnt != i_lat) begin
				cnt <= cnt + 4'h1;
			end else if (i_fault != 2'h0) begin
				o_abort <= 3'h1 << (i_fault - 2'h1);
			end else begin
				o_ack <= 1'b1;
				if (i_we)
					mem[i_addr] = i_wdata;
				o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 32'h0;
			end
		end
	end
endmodule

// [tb/tb.sv]
// Bench: config, registers, transfers both ways, bus faults
`timescale 1ns/1ns
module tb;
	import idebm_pkg::*;
	localparam logic [31:0] B = 32'h1000;
	logic             i_ref_clk, i_arst_n, i_io_rd, i_io_wr, i_cfg_rd, i_cfg_wr, o_io_ack;
	logic             o_cfg_ack, o_mem_req, o_mem_we, i_mem_ack, i_mem_tabort;
	logic             i_mem_mabort, i_mem_perr;
	logic      [31:0] i_io_addr, i_io_wdata, i_cfg_wdata, o_io_rdata, o_cfg_rdata, q;
	logic      [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
	logic      [3:0]  i_io_be, i_cfg_be, lat;
	logic      [7:0]  i_cfg_addr;
	logic      [1:0]  fault, i_intrq, o_chan_active, i_rx_valid, o_rx_ready, o_tx_valid;
	logic      [1:0]  i_tx_ready;
	logic [1:0][31:0] i_rx_data, o_tx_data;
	int               bad_count, tests_run, k;
	logic      [31:0] cause [3] = '{32'h10000000, 32'h20000000, 32'h01000000};
	idebm_top DUT (.*);
	idebm_mem_model pm (.i_ref_clk, .i_arst_n, .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_lat(lat), .i_fault(fault),
		.o_ack(i_mem_ack), .o_rdata(i_mem_rdata), .o_abort({i_mem_perr, i_mem_mabort, i_mem_tabort}));
	always #10 i_ref_clk = ~i_ref_clk;
	task chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task acc(input bit c, w, input logic [31:0] a, d, input logic [3:0] be);
		int n;
		@(posedge i_ref_clk);
		#1;
		if (c) {i_cfg_rd, i_cfg_wr, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {!w, w, a[7:0], be, d};
		else {i_io_rd, i_io_wr, i_io_addr, i_io_be, i_io_wdata} = {!w, w, a, be, d};
		for (n = 0; n < 400 && (c ? o_cfg_ack : o_io_ack) !== 1'b1; n++) begin
			@(posedge i_ref_clk);
			#1;
		end
		q = c ? o_cfg_rdata : o_io_rdata;
		@(posedge i_ref_clk);
		#1;
		{i_cfg_rd, i_cfg_wr, i_io_rd, i_io_wr} = 4'h0;
	endtask
	task rd(input bit c, input logic [31:0] a, m, e, input string nm);
		acc(c, 0, a, 32'h0, 4'hf);
		chk(nm, e, q & m);
	endtask
	task idle(input int ch);
		int n;
		for (n = 0; n < 2000 && o_chan_active[ch] !== 1'b0; n++) begin
			@(posedge i_ref_clk);
			#1;
		end
		chk("active", 32'h0, {31'h0, o_chan_active[ch]});
	endtask
	task push(input int ch, input logic [31:0] d);
		int n;
		{i_rx_valid[ch], i_rx_data[ch]} = {1'b1, d};
		for (n = 0; n < 400 && o_rx_ready[ch] !== 1'b1; n++) begin
			@(posedge i_ref_clk);
			#1;
		end
		@(posedge i_ref_clk);
		#1;
		{i_rx_valid[ch], i_rx_data[ch]} = {1'b0, ~d};
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#1000000; // Far beyond the few hundred cycles the tests need
		bad_count++;
		test_done;
	end
	initial begin
		{i_ref_clk, i_arst_n, i_io_rd, i_io_wr, i_cfg_rd, i_cfg_wr, lat, fault} = 12'h0;
		{i_io_addr, i_io_wdata, i_cfg_wdata, i_io_be, i_cfg_be, i_cfg_addr} = '0;
		{i_intrq, i_rx_valid, i_tx_ready, i_rx_data} = '0;
		repeat (20) @(posedge i_ref_clk);
		#1;
		i_arst_n = 1'b1;
		acc(1, 1, 32'h04, 32'h1, 4'hf);
		acc(1, 1, 32'h20, B, 4'hf);
		rd(1, 32'h20, 32'hfffffff1, B | 32'h1, "bar");
		rd(1, 32'h08, 32'hffff8000, 32'h01018000, "class");
		for (k = 0; k < 2; k++) begin
			rd(0, B + k * 8, 32'h00ff0000, 32'h0, "status reset");
			rd(0, B + k * 8 + 4, 32'hffffffff, 32'h0, "pointer reset");
			acc(0, 1, B + k * 8, 32'h00f80000, 4'h4);
			rd(0, B + k * 8, 32'h00ff0000, 32'h00600000, "status");
			acc(0, 1, B + k * 8 + 4, 32'hffffffff, 4'hf);
			rd(0, B + k * 8 + 4, 32'hffffffff, 32'hfffffffc, "pointer");
		end
		rd(0, B + 32'h10, 32'hffffffff, 32'h0, "unmapped");
		$display("test registers done");
		pm.mem[32'h100] = 32'h2000;
		pm.mem[32'h104] = 32'h4;
		pm.mem[32'h108] = 32'h3000;
		pm.mem[32'h10c] = 32'h80000004;
		acc(0, 1, B + 4, 32'h100, 4'hf);
		acc(0, 1, B, 32'h00660000, 4'h4);
		acc(0, 1, B, 32'h9, 4'h1);
		rd(0, B, 32'h00ff0000, 32'h00610000, "running");
		push(0, 32'h11112222);
		push(0, 32'h33334444);
		idle(0);
		chk("region 0", 32'h11112222, pm.mem[32'h2000]);
		chk("region 1", 32'h33334444, pm.mem[32'h3000]);
		i_intrq[0] = 1'b1;
		acc(0, 1, B, 32'h8, 4'h1);
		rd(0, B, 32'h00ff0000, 32'h00640000, "interrupt");
		acc(0, 1, B, 32'h00640000, 4'h4);
		rd(0, B, 32'h00ff0000, 32'h00600000, "cleared");
		i_intrq[0] = 1'b0;
		$display("test write memory done");
		lat = 4'h6;
		pm.mem[32'h200] = 32'h4000;
		pm.mem[32'h204] = 32'h80000004;
		pm.mem[32'h4000] = 32'ha5a55a5a;
		acc(0, 1, B + 12, 32'h200, 4'hf);
		acc(0, 1, B + 8, 32'h1, 4'h1);
		for (k = 0; k < 400 && o_tx_valid[1] !== 1'b1; k++) begin
			@(posedge i_ref_clk);
			#1;
		end
		chk("to drive", 32'ha5a55a5a, o_tx_data[1]);
		i_tx_ready[1] = 1'b1;
		@(posedge i_ref_clk);
		#1;
		i_tx_ready[1] = 1'b0;
		idle(1);
		acc(0, 1, B + 8, 32'h0, 4'h1);
		acc(0, 1, B + 8, 32'h1, 4'h1);
		rd(0, B + 8, 32'h00ff0001, 32'h00610001, "restart");
		acc(0, 1, B + 8, 32'h0, 4'h1);
		rd(0, B + 8, 32'h00ff0001, 32'h00600000, "stopped");
		$display("test read memory done");
		lat = 4'h0;
		for (k = 0; k < 3; k++) begin
			fault = 2'(k + 1);
			acc(0, 1, B, 32'h1, 4'h1);
			idle(0);
			rd(0, B, 32'h00ff0000, 32'h00620000, "error");
			rd(1, 32'h04, 32'h31000000, cause[k], "cause");
			fault = 2'h0;
			acc(0, 1, B, 32'h00620000, 4'h4);
			rd(0, B, 32'h00ff0000, 32'h00600000, "error clear");
			acc(1, 1, 32'h04, 32'h31000001, 4'hf);
			acc(0, 1, B, 32'h0, 4'h1);
		end
		$display("test faults done");
		test_done;
	end
endmodule
